// ### mnf_exec.sv
// execution datapath for register multiply, negate and no-operation
//
// Behaviour
// - multiply accumulator by byte into product pair
// - multiply leaves accumulator and byte unchanged
// - multiply touches no status flag
// - access bit 0 access bank, 1 bank select
// - negate forms inverse plus one
// - negate writes back, updates N OV C DC Z
`timescale 1ns/1ps
`default_nettype none
module mnf_exec
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [15:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [7:0] o_rdata,
  output mnf_pkg::mnf_mem_req_t o_mem,
  output mnf_pkg::mnf_phase_t o_phase,
  output logic o_retire,
  output logic [4:0] o_status,
  output logic [15:0] o_prod
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic mnf_pkg::mnf_op_t decode_op
  (
    input logic [15:0] instr,
    input logic valid
  );
    mnf_pkg::mnf_op_t op;
    op = mnf_pkg::MNF_OP_NOP;
    if (valid && instr[15:9] == mnf_pkg::OPC_MUL)
    begin
      op = mnf_pkg::MNF_OP_MUL;
    end
    else if (valid && instr[15:9] == mnf_pkg::OPC_NEG)
    begin
      op = mnf_pkg::MNF_OP_NEG;
    end
    return op;
  endfunction

  // bank for a file address; a low access bit overrides bank select
  function automatic logic [3:0] pick_bank
  (
    input logic abit,
    input logic [7:0] f,
    input logic [3:0] bsel
  );
    logic [3:0] bank;
    bank = bsel;
    if (!abit)
    begin
      bank = (f < mnf_pkg::ACC_SPLIT) ? mnf_pkg::ACC_LOW_BANK
                                      : mnf_pkg::ACC_HIGH_BANK;
    end
    return bank;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] accumulator;
  logic [3:0] bank_select_register;
  logic [7:0] product_low_byte;
  logic [7:0] product_high_byte;
  logic [4:0] status;
  logic [7:0] operand;
  mnf_pkg::mnf_op_t op;
  mnf_pkg::mnf_phase_t phase;
  mnf_pkg::mnf_phase_t next_phase;
  logic [7:0] neg_result;
  logic [4:0] neg_carry_lo;
  logic [8:0] neg_carry_all;
  logic [15:0] next_product;
  logic mem_we;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata;

  assign o_mem = {mem_we, mem_addr, mem_wdata};
  assign o_phase = phase;
  assign o_status = status;
  assign o_prod = {product_high_byte, product_low_byte};

  // ----------------------------------------
  // phase sequencer
  // ----------------------------------------
  // four internal phases make one instruction cycle
  always_comb
  begin
    case (phase)
      mnf_pkg::MNF_Q1: next_phase = mnf_pkg::MNF_Q2;
      mnf_pkg::MNF_Q2: next_phase = mnf_pkg::MNF_Q3;
      mnf_pkg::MNF_Q3: next_phase = mnf_pkg::MNF_Q4;
      mnf_pkg::MNF_Q4: next_phase = mnf_pkg::MNF_Q1;
      default: next_phase = mnf_pkg::MNF_Q1;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      phase <= mnf_pkg::MNF_Q1;
      o_retire <= 1'b0;
    end
    else if (i_ce)
    begin
      phase <= next_phase;
      o_retire <= (phase == mnf_pkg::MNF_Q4);
    end
  end

  // ----------------------------------------
  // decode (Q1) and operand address (Q2)
  // ----------------------------------------
  // the address is registered so memory sees it from Q2 until Q4 ends
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      op <= mnf_pkg::MNF_OP_NOP;
      mem_addr <= '0;
    end
    else if (i_ce && phase == mnf_pkg::MNF_Q1)
    begin
      op <= decode_op(i_instr, i_instr_valid);
      mem_addr <= {pick_bank(i_instr[8], i_instr[7:0],
                             bank_select_register),
                   i_instr[7:0]};
    end
  end

  // ----------------------------------------
  // process (Q3)
  // ----------------------------------------
  assign neg_result = ~i_mem_rdata + 8'h01;
  assign neg_carry_lo = {1'b0, ~operand[3:0]} + 5'h01;
  assign neg_carry_all = {1'b0, ~operand} + 9'h001;
  assign next_product = 16'(accumulator) * 16'(operand);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      operand <= mnf_pkg::RST_BYTE;
    end
    else if (i_ce && phase == mnf_pkg::MNF_Q3)
    begin
      operand <= i_mem_rdata;
    end
  end

  // memory write strobe stands for Q4 only, and only for negate
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      mem_we <= 1'b0;
      mem_wdata <= mnf_pkg::RST_BYTE;
    end
    else if (i_ce)
    begin
      mem_we <= (phase == mnf_pkg::MNF_Q3) &&
                (op == mnf_pkg::MNF_OP_NEG);
      if (phase == mnf_pkg::MNF_Q3)
      begin
        mem_wdata <= neg_result;
      end
    end
  end

  // ----------------------------------------
  // write back (Q4)
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      product_low_byte <= mnf_pkg::RST_BYTE;
      product_high_byte <= mnf_pkg::RST_BYTE;
    end
    else if (i_ce && phase == mnf_pkg::MNF_Q4 &&
             op == mnf_pkg::MNF_OP_MUL)
    begin
      product_low_byte <= next_product[7:0];
      product_high_byte <= next_product[15:8];
    end
  end

  // flags move only for negate; a zero product raises nothing
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      status <= mnf_pkg::RST_STATUS;
    end
    else if (i_ce && phase == mnf_pkg::MNF_Q4 &&
             op == mnf_pkg::MNF_OP_NEG)
    begin
      status[mnf_pkg::ST_C] <= neg_carry_all[8];
      status[mnf_pkg::ST_DC] <= neg_carry_lo[4];
      status[mnf_pkg::ST_Z] <= (o_mem.wdata == 8'h00);
      status[mnf_pkg::ST_OV] <= (operand == 8'h80);
      status[mnf_pkg::ST_N] <= o_mem.wdata[7];
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  // accumulator and bank select belong to software only
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      accumulator <= mnf_pkg::RST_BYTE;
      bank_select_register <= mnf_pkg::RST_BANK;
    end
    else if (i_ce && i_we)
    begin
      if (i_addr == mnf_pkg::ADDR_ACC)
      begin
        accumulator <= i_wdata;
      end
      if (i_addr == mnf_pkg::ADDR_BANK)
      begin
        bank_select_register <= i_wdata[3:0];
      end
    end
  end

  // read data stand for one cycle; unmapped reads give zero
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_ce)
    begin
      o_rdata <= 8'h00;
      if (i_re)
      begin
        case (i_addr)
          mnf_pkg::ADDR_ACC: o_rdata <= accumulator;
          mnf_pkg::ADDR_BANK: o_rdata <= {4'h0, bank_select_register};
          mnf_pkg::ADDR_PROD_LO: o_rdata <= product_low_byte;
          mnf_pkg::ADDR_PROD_HI: o_rdata <= product_high_byte;
          mnf_pkg::ADDR_STATUS: o_rdata <= {3'h0, status};
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // cycles with the enable low are invisible to these checks
  default clocking cb @(posedge i_ref_clk iff i_ce);
  endclocking
  default disable iff (i_rst);
  logic [7:0] q1_f;
  logic q1_a;
  logic [3:0] q1_bank;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_ce && phase == mnf_pkg::MNF_Q1)
    begin
      q1_f <= i_instr[7:0];
      q1_a <= i_instr[8];
      q1_bank <= bank_select_register;
    end
  end
  a_mul_product: assert property (
    (phase == mnf_pkg::MNF_Q4 && op == mnf_pkg::MNF_OP_MUL) |=>
      o_prod == 16'($past(accumulator)) * 16'($past(operand)))
    else $error("product pair wrong after multiply");
  a_mul_no_write: assert property (
    (phase == mnf_pkg::MNF_Q1 && op == mnf_pkg::MNF_OP_MUL) |->
      !o_mem.we && $past(!o_mem.we) && $past(!o_mem.we, 2))
    else $error("multiply wrote data memory");
  a_mul_flags_kept: assert property (
    (phase == mnf_pkg::MNF_Q4 && op != mnf_pkg::MNF_OP_NEG) |=>
      $stable(status))
    else $error("status changed outside negate");
  a_bank_access: assert property (
    (phase == mnf_pkg::MNF_Q2 && !q1_a) |->
      o_mem.addr[11:8] == ((q1_f < 8'h80) ? 4'h0 : 4'hF))
    else $error("access bank not used with access bit low");
  a_bank_select: assert property (
    (phase == mnf_pkg::MNF_Q2 && q1_a) |->
      o_mem.addr == {q1_bank, q1_f})
    else $error("bank select not used with access bit high");
  a_neg_value: assert property (
    (phase == mnf_pkg::MNF_Q4 && op == mnf_pkg::MNF_OP_NEG) |->
      o_mem.we && o_mem.wdata == 8'(~operand + 8'h01))
    else $error("negate result wrong");
  a_neg_flags: assert property (
    (phase == mnf_pkg::MNF_Q4 && op == mnf_pkg::MNF_OP_NEG) |=>
      status[mnf_pkg::ST_Z] == ($past(operand) == 8'h00) &&
      status[mnf_pkg::ST_C] == ($past(operand) == 8'h00) &&
      status[mnf_pkg::ST_DC] == ($past(operand[3:0]) == 4'h0) &&
      status[mnf_pkg::ST_OV] == ($past(operand) == 8'h80) &&
      status[mnf_pkg::ST_N] == $past(o_mem.wdata[7]))
    else $error("negate flags wrong");
  a_neg_same_addr: assert property (
    (phase == mnf_pkg::MNF_Q2) |=> $stable(o_mem.addr) [*2])
    else $error("address moved between read and write");
  a_cycle_four: assert property (
    (phase == mnf_pkg::MNF_Q1 && !i_rst) |-> // reset edge holds Q1
      ##4 (phase == mnf_pkg::MNF_Q1 && o_retire))
    else $error("instruction cycle not four phases");
  a_nop_quiet: assert property (
    (phase == mnf_pkg::MNF_Q4 && op == mnf_pkg::MNF_OP_NOP) |->
      !o_mem.we ##1 $stable(o_prod) && $stable(status))
    else $error("no-operation changed state");

  c_mul_done: cover property (
    phase == mnf_pkg::MNF_Q4 && op == mnf_pkg::MNF_OP_MUL);
  c_neg_overflow: cover property (
    phase == mnf_pkg::MNF_Q4 && op == mnf_pkg::MNF_OP_NEG &&
    operand == 8'h80);
  c_neg_zero: cover property (
    phase == mnf_pkg::MNF_Q4 && op == mnf_pkg::MNF_OP_NEG &&
    operand == 8'h00);
  c_nop_done: cover property (
    phase == mnf_pkg::MNF_Q4 && op == mnf_pkg::MNF_OP_NOP);
endmodule // mnf_exec
`default_nettype wire

// ### mnf_pkg.sv
// constants and types for the multiply / negate / no-operation datapath
`default_nettype none
package mnf_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned MEM_AW = 12;
  localparam int unsigned REG_AW = 3;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned STAT_W = 5;
  // ----------------------------------------
  // register port offsets
  // ----------------------------------------
  localparam logic [2:0] ADDR_ACC = 3'h0;
  localparam logic [2:0] ADDR_BANK = 3'h1;
  localparam logic [2:0] ADDR_PROD_LO = 3'h2;
  localparam logic [2:0] ADDR_PROD_HI = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  // ----------------------------------------
  // status flag positions
  // ----------------------------------------
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_N = 4;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [4:0] RST_STATUS = 5'h00;
  // ----------------------------------------
  // opcodes and access bank
  // ----------------------------------------
  localparam logic [6:0] OPC_MUL = 7'h01;
  localparam logic [6:0] OPC_NEG = 7'h36;
  localparam logic [15:0] OPC_NOP = 16'h0000;
  localparam logic [3:0] OPC_NOP_ALT = 4'hF;
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MNF_Q1 = 2'b00,
    MNF_Q2 = 2'b01,
    MNF_Q3 = 2'b10,
    MNF_Q4 = 2'b11
  } mnf_phase_t;
  typedef enum logic [1:0] {
    MNF_OP_NOP = 2'b00,
    MNF_OP_MUL = 2'b01,
    MNF_OP_NEG = 2'b10
  } mnf_op_t;
  typedef struct packed {
    logic we;
    logic [MEM_AW-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } mnf_mem_req_t;
endpackage
`default_nettype wire

// ### tb.sv
// self-checking bench for the multiply / negate / no-operation datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [15:0] i_instr = 16'h0000;
  logic i_instr_valid = 1'b0;
  logic [7:0] i_mem_rdata = 8'h00;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_we = 1'b0;
  logic i_re = 1'b0;
  logic [7:0] o_rdata;
  mnf_pkg::mnf_mem_req_t o_mem;
  mnf_pkg::mnf_phase_t o_phase;
  logic o_retire;
  logic [4:0] o_status;
  logic [15:0] o_prod;
  logic [7:0] mem [0:4095];
  logic [7:0] exp_mem [0:4095];
  logic [7:0] m_acc = 8'h00;
  logic [3:0] m_bank = 4'h0;
  logic [15:0] m_prod = 16'h0000;
  logic [4:0] m_stat = 5'h00;
  logic [1:0] frz;
  // flag boundary bytes: plain, zero, most negative, largest, nibble carry
  localparam logic [39:0] EDGE_BYTES = 40'h3A00807F10;
  int error_cnt = 0;
  int n_compared = 0;

  initial
  begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  mnf_exec i_dut
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_instr(i_instr),
    .i_instr_valid(i_instr_valid),
    .i_mem_rdata(i_mem_rdata),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_we(i_we),
    .i_re(i_re),
    .o_rdata(o_rdata),
    .o_mem(o_mem),
    .o_phase(o_phase),
    .o_retire(o_retire),
    .o_status(o_status),
    .o_prod(o_prod)
  );

  // ----
  // data memory: one-cycle read, so the address must stand from Q2
  // ----
  always @(posedge i_ref_clk)
  begin
    i_mem_rdata <= mem[o_mem.addr];
    if (o_mem.we)
      mem[o_mem.addr] <= o_mem.wdata;
  end

  // ----
  // tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_ref_clk);
    i_we <= 1'b0;
    if (a == mnf_pkg::ADDR_ACC)
      m_acc = v;
    if (a == mnf_pkg::ADDR_BANK)
      m_bank = v[3:0];
  endtask

  task automatic rchk(input logic [2:0] a);
    logic [7:0] e;
    case (a)
      3'h0: e = m_acc;
      3'h1: e = {4'h0, m_bank};
      3'h2: e = m_prod[7:0];
      3'h3: e = m_prod[15:8];
      3'h4: e = {3'h0, m_stat};
      default: e = 8'h00;
    endcase
    @(posedge i_ref_clk);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_re <= 1'b0;
    @(negedge i_ref_clk);
    check(o_rdata, e);
  endtask

  // op: 0 no-op, 1 multiply, 2 negate, 3 negate word marked invalid
  task automatic run(input int op, input logic a, input logic [7:0] f);
    logic [11:0] ad;
    logic [7:0] b;
    logic [7:0] r;
    int eff;
    int k;
    eff = (op == 3) ? 0 : op;
    ad = {a ? m_bank : (f < mnf_pkg::ACC_SPLIT ? mnf_pkg::ACC_LOW_BANK
      : mnf_pkg::ACC_HIGH_BANK), f};
    b = exp_mem[ad];
    r = ~b + 8'h01;
    k = 0;
    @(negedge i_ref_clk);
    while (o_phase !== mnf_pkg::MNF_Q4 && k < 8)
    begin
      @(negedge i_ref_clk);
      k++;
    end
    if (k == 8)
    begin
      error_cnt++;
      complete_run();
    end
    @(posedge i_ref_clk);
    i_instr <= (op == 0) ? {mnf_pkg::OPC_NOP_ALT, 3'h0, a, f}
      : {(op == 1) ? mnf_pkg::OPC_MUL : mnf_pkg::OPC_NEG, a, f};
    i_instr_valid <= (op != 3);
    @(posedge i_ref_clk);
    i_instr_valid <= 1'b0;
    i_instr <= 16'($urandom);
    @(negedge i_ref_clk);
    check(o_phase, mnf_pkg::MNF_Q2);
    if (eff != 0)
      check(o_mem.addr, ad);
    repeat (2) @(negedge i_ref_clk);
    check(o_mem.we, eff == 2);
    if (eff == 2)
      check(o_mem.wdata, r);
    if (eff == 1)
      m_prod = 16'(m_acc) * 16'(b);
    if (eff == 2)
    begin
      exp_mem[ad] = r;
      m_stat = {r[7], b == 8'h80, r == 8'h00, b[3:0] == 4'h0, b == 8'h00};
    end
    @(negedge i_ref_clk);
    check(o_retire, 1'b1);
    check(o_prod, m_prod);
    check(o_status, m_stat);
    check(mem[ad], exp_mem[ad]);
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    void'($urandom(32'h419E));
    for (int i = 0; i < 4096; i++)
    begin
      mem[i] = 8'($urandom);
      exp_mem[i] = mem[i];
    end
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int a = 0; a < 8; a++)
      rchk(3'(a));
    wr(mnf_pkg::ADDR_BANK, 8'hFF);
    wr(mnf_pkg::ADDR_PROD_LO, 8'h55);
    wr(mnf_pkg::ADDR_STATUS, 8'h1F);
    wr(3'h7, 8'h12);
    for (int a = 1; a < 5; a++)
      rchk(3'(a));
    wr(mnf_pkg::ADDR_ACC, 8'hC4);
    wr(mnf_pkg::ADDR_BANK, 8'h03);
    mem[12'h310] = 8'hB5;
    exp_mem[12'h310] = 8'hB5;
    run(1, 1'b1, 8'h10);
    check(o_prod, 16'h8A94);
    for (int i = 0; i < 5; i++)
    begin
      mem[12'h320 + i] = EDGE_BYTES[39 - 8 * i -: 8];
      exp_mem[12'h320 + i] = mem[12'h320 + i];
      run(2, 1'b1, 8'h20 + 8'(i));
    end
    run(2, 1'b0, 8'hA5);
    run(1, 1'b0, 8'h21);
    // a low enable must hold every register, even under a write strobe
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    i_we <= 1'b1;
    i_addr <= mnf_pkg::ADDR_ACC;
    i_wdata <= ~m_acc;
    @(negedge i_ref_clk);
    frz = o_phase;
    @(posedge i_ref_clk);
    i_we <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_ce <= 1'b1;
    @(negedge i_ref_clk);
    check(o_phase, frz);
    check(o_prod, m_prod);
    rchk(mnf_pkg::ADDR_ACC);
    for (int i = 0; i < 80; i++)
    begin
      if (i % 8 == 0)
      begin
        wr(mnf_pkg::ADDR_ACC, 8'($urandom));
        wr(mnf_pkg::ADDR_BANK, 8'($urandom));
      end
      run($urandom % 4, 1'($urandom), 8'($urandom));
      if (i % 8 == 7)
        rchk(mnf_pkg::ADDR_ACC);
    end
    for (int a = 0; a < 5; a++)
      rchk(3'(a));
    complete_run();
  end
endmodule // tb
`default_nettype wire
